// [pkg/osc_ctrl_pkg.sv]
// constants and register layout of the oscillator control and warm-up timer
//
// Function
// - the fast warm-up counter is 16 bits wide and the slow one is 18 bits wide.
// - the lowest four counter bits take no part in the compare.
// - fast warm-up compares the 12-bit count, slow warm-up a 14-bit value of count and extension.
// - bits 31 to 20 hold the 12-bit count, read/write, which is the whole fast compare value.
// - for slow warm-up the same 12-bit field forms the upper 12 bits of the compare value.
// - bits 15 to 14 hold a 2-bit read/write extension, the lowest bits of the slow compare value.
// - bit 9 stops (0) or runs (1) the slow oscillator and resets to 1.
// - bit 8 stops (0) or runs (1) the fast oscillator and resets to 1.
// - bit 3 picks the warm-up timer clock, 0 fast and 1 slow, and the timer counts on it.
// - bit 2 stops (0) or runs (1) the PLL and resets to 0.
// - read-only bit 1 reads 1 while a warm-up runs and 0 once it is done.
// - writing 1 to bit 0 starts a warm-up, writing 0 does nothing, and it reads as 0.
package osc_ctrl_pkg;
  localparam int unsigned FAST_CNT_W = 16;
  localparam int unsigned SLOW_CNT_W = 18;
  localparam int unsigned CNT_MASK_W = 4;
  localparam int unsigned CMP_HI_W = 12;
  localparam int unsigned CMP_LO_W = 2;
  localparam int unsigned CMP_SLOW_W = CMP_HI_W + CMP_LO_W;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OSC_CTRL_OFFSET = 4'h4;
  // field positions
  localparam int unsigned COUNT_MSB = 31;
  localparam int unsigned COUNT_LSB = 20;
  localparam int unsigned EXT_MSB = 15;
  localparam int unsigned EXT_LSB = 14;
  localparam int unsigned RSV_MSB = 13;
  localparam int unsigned RSV_LSB = 12;
  localparam int unsigned SLOW_EN_BIT = 9;
  localparam int unsigned FAST_EN_BIT = 8;
  localparam int unsigned PAT_MSB = 7;
  localparam int unsigned PAT_LSB = 4;
  localparam int unsigned SRC_SEL_BIT = 3;
  localparam int unsigned PLL_RUN_BIT = 2;
  localparam int unsigned BUSY_BIT = 1;
  localparam int unsigned START_BIT = 0;
  // reset values
  localparam logic [11:0] COUNT_RST = 12'h800;
  localparam logic [1:0] EXT_RST = 2'h0;
  localparam logic [1:0] RSV_RST = 2'h0;
  localparam logic [3:0] PAT_RST = 4'h3;
  localparam logic SLOW_EN_RST = 1'b1;
  localparam logic FAST_EN_RST = 1'b1;
  localparam logic SRC_SEL_RST = 1'b0;
  localparam logic PLL_RUN_RST = 1'b0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    WU_IDLE = 2'b01,
    WU_RUN = 2'b10
  } warmup_state_t;
endpackage

// [pkg/osc_sel_if.sv]
// interface carrying the selected oscillator edge pulse into the control block
interface osc_sel_if;
  logic srcSel;
  logic tick;
  modport sel (input srcSel, output tick);
  modport ctl (output srcSel, input tick);
endinterface

// [verilog/osc_edge_sync.sv]
// synchronises both oscillator clocks and gives one tick per rising edge of the selected one
module osc_edge_sync
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic fastOscClk,
  input wire logic slowOscClk,
  osc_sel_if.sel sel
);
  logic [1:0] fastMeta_q;
  logic [1:0] slowMeta_q;
  logic fastLast_q;
  logic slowLast_q;
  logic tick_q;

  ////////////////////////////////////////////////////////////////////
  // two-stage synchronisers; only stage two is looked at
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fastMeta_q <= 2'h0;
      slowMeta_q <= 2'h0;
    end
    else
    begin
      fastMeta_q <= {fastMeta_q[0], fastOscClk};
      slowMeta_q <= {slowMeta_q[0], slowOscClk};
    end
  end

  // rising edge of the chosen clock; the core clock must be over twice the oscillator rate
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fastLast_q <= 1'b0;
      slowLast_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      fastLast_q <= fastMeta_q[1];
      slowLast_q <= slowMeta_q[1];
      tick_q <= sel.srcSel ? (slowMeta_q[1] & ~slowLast_q)
                           : (fastMeta_q[1] & ~fastLast_q);
    end
  end

  assign sel.tick = tick_q;
endmodule // osc_edge_sync

// [verilog/osc_warmup_ctrl.sv]
// oscillator control register and warm-up timer
//
// Design decisions made here: the placing of the registers and the strobed register port.
module osc_warmup_ctrl
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic fastOscClk,
  input wire logic slowOscClk,
  output logic fastOscEn,
  output logic slowOscEn,
  output logic pllRun,
  output logic warmupBusy
);
  osc_sel_if selIf ();

  logic [11:0] count_q;
  logic [1:0] ext_q;
  logic [1:0] rsv_q;
  logic [3:0] pat_q;
  logic slowEn_q;
  logic fastEn_q;
  logic srcSel_q;
  logic pllRun_q;
  logic busy_q;
  logic [31:0] rdata_q;
  logic [osc_ctrl_pkg::SLOW_CNT_W-1:0] cnt_q;
  osc_ctrl_pkg::warmup_state_t state_q;
  logic ctrlWr;
  logic startReq;
  logic hitFast;
  logic hitSlow;
  logic done;
  logic [31:0] regImage;

  osc_edge_sync edgeSync
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .fastOscClk(fastOscClk),
    .slowOscClk(slowOscClk),
    .sel(selIf.sel)
  );

  assign selIf.srcSel = srcSel_q;

  ////////////////////////////////////////////////////////////////////
  // decode
  assign ctrlWr = regWr && (regAddr == osc_ctrl_pkg::OSC_CTRL_OFFSET);
  assign startReq = ctrlWr && regWdata[osc_ctrl_pkg::START_BIT];

  // compare only counter bits above the masked low four
  assign hitFast = (cnt_q[osc_ctrl_pkg::FAST_CNT_W-1:osc_ctrl_pkg::CNT_MASK_W]
                    == count_q);
  assign hitSlow = (cnt_q[osc_ctrl_pkg::SLOW_CNT_W-1:osc_ctrl_pkg::CNT_MASK_W]
                    == {count_q, ext_q});
  assign done = (state_q == osc_ctrl_pkg::WU_RUN) && (srcSel_q ? hitSlow : hitFast);

  ////////////////////////////////////////////////////////////////////
  // writable control fields, one process per field
  // count field: whole fast compare value, top of the slow one
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_q <= osc_ctrl_pkg::COUNT_RST;
    end
    else if (ctrlWr)
    begin
      count_q <= regWdata[osc_ctrl_pkg::COUNT_MSB:osc_ctrl_pkg::COUNT_LSB];
    end
  end

  // extension: lowest two bits of the slow compare, ignored in fast warm-up
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_q <= osc_ctrl_pkg::EXT_RST;
    end
    else if (ctrlWr)
    begin
      ext_q <= regWdata[osc_ctrl_pkg::EXT_MSB:osc_ctrl_pkg::EXT_LSB];
    end
  end

  // stored as written so software sees its own value; it steers nothing
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rsv_q <= osc_ctrl_pkg::RSV_RST;
    end
    else if (ctrlWr)
    begin
      rsv_q <= regWdata[osc_ctrl_pkg::RSV_MSB:osc_ctrl_pkg::RSV_LSB];
    end
  end

  // fixed pattern field, kept as written for the same reason
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pat_q <= osc_ctrl_pkg::PAT_RST;
    end
    else if (ctrlWr)
    begin
      pat_q <= regWdata[osc_ctrl_pkg::PAT_MSB:osc_ctrl_pkg::PAT_LSB];
    end
  end

  // slow oscillator run
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      slowEn_q <= osc_ctrl_pkg::SLOW_EN_RST;
    end
    else if (ctrlWr)
    begin
      slowEn_q <= regWdata[osc_ctrl_pkg::SLOW_EN_BIT];
    end
  end

  // fast oscillator run
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fastEn_q <= osc_ctrl_pkg::FAST_EN_RST;
    end
    else if (ctrlWr)
    begin
      fastEn_q <= regWdata[osc_ctrl_pkg::FAST_EN_BIT];
    end
  end

  // warm-up source; changing it mid warm-up swaps the compare in flight
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      srcSel_q <= osc_ctrl_pkg::SRC_SEL_RST;
    end
    else if (ctrlWr)
    begin
      srcSel_q <= regWdata[osc_ctrl_pkg::SRC_SEL_BIT];
    end
  end

  // pll run; software owns the settling delay after a multiplier change
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pllRun_q <= osc_ctrl_pkg::PLL_RUN_RST;
    end
    else if (ctrlWr)
    begin
      pllRun_q <= regWdata[osc_ctrl_pkg::PLL_RUN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // warm-up state; a start in the finishing cycle restarts, so it is not lost
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= osc_ctrl_pkg::WU_IDLE;
    end
    else
    begin
      unique case (state_q)
        osc_ctrl_pkg::WU_IDLE:
        begin
          if (startReq)
          begin
            state_q <= osc_ctrl_pkg::WU_RUN;
          end
        end
        osc_ctrl_pkg::WU_RUN:
        begin
          if (done && !startReq)
          begin
            state_q <= osc_ctrl_pkg::WU_IDLE;
          end
        end
        default:
        begin
          state_q <= osc_ctrl_pkg::WU_IDLE;
        end
      endcase
    end
  end

  // busy kept in its own flop so the pin never hangs on a state decode
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0;
    end
    else if (startReq)
    begin
      busy_q <= 1'b1;
    end
    else if (done)
    begin
      busy_q <= 1'b0;
    end
  end

  // counter clears on start and advances on each selected oscillator edge while a warm-up runs
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= '0;
    end
    else if (startReq)
    begin
      cnt_q <= '0;
    end
    else if ((state_q == osc_ctrl_pkg::WU_RUN) && !done && selIf.tick)
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the read strobe
  always_comb
  begin
    regImage = osc_ctrl_pkg::READ_ZERO;
    regImage[osc_ctrl_pkg::COUNT_MSB:osc_ctrl_pkg::COUNT_LSB] = count_q;
    regImage[osc_ctrl_pkg::EXT_MSB:osc_ctrl_pkg::EXT_LSB] = ext_q;
    regImage[osc_ctrl_pkg::RSV_MSB:osc_ctrl_pkg::RSV_LSB] = rsv_q;
    regImage[osc_ctrl_pkg::PAT_MSB:osc_ctrl_pkg::PAT_LSB] = pat_q;
    regImage[osc_ctrl_pkg::SLOW_EN_BIT] = slowEn_q;
    regImage[osc_ctrl_pkg::FAST_EN_BIT] = fastEn_q;
    regImage[osc_ctrl_pkg::SRC_SEL_BIT] = srcSel_q;
    regImage[osc_ctrl_pkg::PLL_RUN_BIT] = pllRun_q;
    regImage[osc_ctrl_pkg::BUSY_BIT] = (state_q == osc_ctrl_pkg::WU_RUN);
    regImage[osc_ctrl_pkg::START_BIT] = 1'b0;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= osc_ctrl_pkg::READ_ZERO;
    end
    else if (regRd && (regAddr == osc_ctrl_pkg::OSC_CTRL_OFFSET))
    begin
      rdata_q <= regImage;
    end
    else
    begin
      rdata_q <= osc_ctrl_pkg::READ_ZERO; // unmapped and idle read as zero
    end
  end

  assign regRdata = rdata_q;
  assign fastOscEn = fastEn_q;
  assign slowOscEn = slowEn_q;
  assign pllRun = pllRun_q;
  assign warmupBusy = busy_q;

  ////////////////////////////////////////////////////////////////////
  // checks
  // warm-up sequencing
  AST_START_BUSY: assert property (@(posedge core_clk) disable iff (!nrst)
    startReq |=> warmupBusy) else $error("start did not set busy");
  AST_DONE_CLEARS: assert property (@(posedge core_clk) disable iff (!nrst)
    (done && !startReq) |=> !warmupBusy) else $error("busy not cleared on match");
  AST_NO_EARLY_END: assert property (@(posedge core_clk) disable iff (!nrst)
    (warmupBusy && !done) |=> warmupBusy) else $error("warm-up ended early");
  AST_BUSY_FLOP: assert property (@(posedge core_clk) disable iff (!nrst)
    warmupBusy == (state_q == osc_ctrl_pkg::WU_RUN)) else $error("busy and state differ");
  // read side
  AST_START_READ_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    regRd |=> !regRdata[osc_ctrl_pkg::START_BIT]) else $error("start bit read 1");
  AST_BUSY_READ: assert property (@(posedge core_clk) disable iff (!nrst)
    (regRd && regAddr == osc_ctrl_pkg::OSC_CTRL_OFFSET)
    |=> regRdata[osc_ctrl_pkg::BUSY_BIT] == $past(warmupBusy)) else $error("busy read wrong");
  AST_COUNT_READ: assert property (@(posedge core_clk) disable iff (!nrst)
    (regRd && regAddr == osc_ctrl_pkg::OSC_CTRL_OFFSET)
    |=> regRdata[osc_ctrl_pkg::COUNT_MSB:osc_ctrl_pkg::COUNT_LSB] == $past(count_q))
    else $error("count field read wrong");
  AST_EXT_READ: assert property (@(posedge core_clk) disable iff (!nrst)
    (regRd && regAddr == osc_ctrl_pkg::OSC_CTRL_OFFSET)
    |=> regRdata[osc_ctrl_pkg::EXT_MSB:osc_ctrl_pkg::EXT_LSB] == $past(ext_q))
    else $error("extension read wrong");
  AST_IDLE_READ_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    !(regRd && regAddr == osc_ctrl_pkg::OSC_CTRL_OFFSET)
    |=> regRdata == osc_ctrl_pkg::READ_ZERO) else $error("idle read data not zero");
  AST_RSV_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    regRdata[osc_ctrl_pkg::COUNT_LSB-1:osc_ctrl_pkg::EXT_MSB+1] == 4'h0
    && regRdata[osc_ctrl_pkg::RSV_LSB-1:osc_ctrl_pkg::SLOW_EN_BIT+1] == 2'h0)
    else $error("reserved bits not 0");
  // control fields
  AST_FAST_EN_WR: assert property (@(posedge core_clk) disable iff (!nrst)
    ctrlWr |=> fastOscEn == $past(regWdata[osc_ctrl_pkg::FAST_EN_BIT]))
    else $error("fast enable not written");
  AST_FAST_EN_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    !ctrlWr |=> fastOscEn == $past(fastOscEn)) else $error("fast enable moved");
  AST_SLOW_EN_WR: assert property (@(posedge core_clk) disable iff (!nrst)
    ctrlWr |=> slowOscEn == $past(regWdata[osc_ctrl_pkg::SLOW_EN_BIT]))
    else $error("slow enable not written");
  AST_SLOW_EN_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    !ctrlWr |=> slowOscEn == $past(slowOscEn)) else $error("slow enable moved");
  AST_SRC_SEL_WR: assert property (@(posedge core_clk) disable iff (!nrst)
    ctrlWr |=> srcSel_q == $past(regWdata[osc_ctrl_pkg::SRC_SEL_BIT]))
    else $error("source select not written");
  AST_PLL_WR: assert property (@(posedge core_clk) disable iff (!nrst)
    ctrlWr |=> pllRun == $past(regWdata[osc_ctrl_pkg::PLL_RUN_BIT]))
    else $error("pll run not written");
  AST_PLL_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    !ctrlWr |=> pllRun == $past(pllRun)) else $error("pll run changed without write");
  // counter
  AST_CNT_HOLD_IDLE: assert property (@(posedge core_clk) disable iff (!nrst)
    (!warmupBusy && !startReq) |=> cnt_q == $past(cnt_q)) else $error("counter moved idle");
  AST_START_CLR_CNT: assert property (@(posedge core_clk) disable iff (!nrst)
    startReq |=> cnt_q == '0) else $error("start did not clear counter");
  AST_CNT_TICK: assert property (@(posedge core_clk) disable iff (!nrst)
    (warmupBusy && !done && !startReq && selIf.tick) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("counter missed a tick");
  AST_CNT_NO_TICK: assert property (@(posedge core_clk) disable iff (!nrst)
    (warmupBusy && !startReq && !selIf.tick) |=> cnt_q == $past(cnt_q))
    else $error("counter moved without tick");
  // the match checks decode the compare themselves instead of trusting the done term
  AST_FAST_MATCH: assert property (@(posedge core_clk) disable iff (!nrst)
    (warmupBusy && !srcSel_q && !startReq
     && cnt_q[osc_ctrl_pkg::FAST_CNT_W-1:osc_ctrl_pkg::CNT_MASK_W] == count_q)
    |=> !warmupBusy) else $error("fast match did not end warm-up");
  AST_SLOW_MATCH: assert property (@(posedge core_clk) disable iff (!nrst)
    (warmupBusy && srcSel_q && !startReq
     && cnt_q[osc_ctrl_pkg::SLOW_CNT_W-1:osc_ctrl_pkg::CNT_MASK_W] == {count_q, ext_q})
    |=> !warmupBusy) else $error("slow match did not end warm-up");
endmodule // osc_warmup_ctrl

// [verif/test_osc_warmup_ctrl.sv]
// self-checking bench of the oscillator control register and warm-up timer
`define CHK(nm, ex, gt) begin nCompared++; if ((gt) !== (ex)) begin fails++; \
  $display("wrong value %s exp %h seen %h", nm, ex, gt); end end
module test_osc_warmup_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic fastOscClk = 1'b0;
  logic slowOscClk = 1'b0;
  logic fastOscEn, slowOscEn, pllRun, warmupBusy;
  int fails = 0;
  int nCompared = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_91f1;
  logic [31:0] d, w;
  osc_warmup_ctrl dut
  (
    .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .fastOscClk(fastOscClk),
    .slowOscClk(slowOscClk), .fastOscEn(fastOscEn), .slowOscEn(slowOscEn),
    .pllRun(pllRun), .warmupBusy(warmupBusy)
  );
  //////////////////////////////////////////////////////////////////////////////
  // core clock 100 ns; oscillators slower than half of it, phases unrelated
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  initial
  begin
    #37;
    forever #500 fastOscClk = ~fastOscClk;
  end
  initial
  begin
    #411;
    forever #1300 slowOscClk = ~slowOscClk;
  end
  // hang guard, well above the longest warm-up
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      testDone();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // readable image: stored fields kept, reserved bits zero, start bit zero
  function automatic logic [31:0] expImg(input logic [31:0] v, input logic busy);
    return {v[31:20], 4'h0, v[15:12], 2'b00, v[9:2], busy, 1'b0};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    v = regRdata;
  endtask
  // start a warm-up and bound its length in core cycles
  task automatic warmup(input logic [31:0] v, input int lo, input int hi);
    int n;
    wr(4'h4, v);
    `CHK("busy after start", 1'b1, warmupBusy)
    rd(4'h4, d);
    `CHK("busy bit", expImg(v, 1'b1), d)
    n = 2;
    while (warmupBusy !== 1'b0 && n < hi + 5)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK("warm-up not short", 1'b1, n >= lo)
    `CHK("warm-up not long", 1'b1, n <= hi)
    rd(4'h4, d);
    `CHK("done bit", expImg(v, 1'b0), d)
  endtask
  task automatic testDone();
    $display("compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    `CHK("fast enable reset", 1'b1, fastOscEn)
    `CHK("slow enable reset", 1'b1, slowOscEn)
    `CHK("pll reset", 1'b0, pllRun)
    rd(4'h4, d);
    `CHK("reset image", 32'h8000_0330, d)
    // keep the pll stopped past its settling time before random writes may run it
    repeat (1001) @(posedge core_clk);
    // random legal writes, start bit low so no warm-up may begin
    for (int i = 0; i < 12; i++)
    begin
      seed = xorshift(seed);
      w = (seed & 32'hfff0_c30c) | 32'h0000_0030;
      wr(4'h4, w);
      `CHK("fast enable", w[8], fastOscEn)
      `CHK("slow enable", w[9], slowOscEn)
      `CHK("pll run", w[2], pllRun)
      rd(4'h4, d);
      `CHK("readback", expImg(w, 1'b0), d)
      // unmapped address: write ignored, read zero
      seed = xorshift(seed);
      wr((seed[3:0] == 4'h4) ? 4'h5 : seed[3:0], ~w);
      rd((seed[3:0] == 4'h4) ? 4'h5 : seed[3:0], d);
      `CHK("unmapped read", 32'h0000_0000, d)
      rd(4'h4, d);
      `CHK("unmapped write", expImg(w, 1'b0), d)
    end
    // fast: count 2 means 32 fast edges; extension must not matter
    warmup(32'h0020_c331, 300, 340);
    // slow: count 0 with extension 1 means 16 slow edges
    warmup(32'h0000_4339, 380, 432);
    // slow: count 1 with extension 0 means 64 slow edges
    warmup(32'h0010_0339, 1640, 1690);
    testDone();
  end
endmodule // test_osc_warmup_ctrl
